/* hdl/dicr_pkg.sv */
// Shared constants and carrier types of the DDR input capture register.
`default_nettype none
package dicr_pkg;
  localparam int DICR_DATA_W = 8;
  localparam int DICR_DELAY_STAGES = 2;
  localparam int DICR_BUF_DEPTH = 2;
  localparam int DICR_SYNC_FLOPS = 3;
  localparam logic [7:0] DICR_DATA_RESET = 8'h00;
  localparam logic DICR_MODE_SDR = 1'b0;
  localparam logic DICR_MODE_DDR = 1'b1;
  localparam logic DICR_POL_RISE = 1'b0;
  localparam logic DICR_POL_FALL = 1'b1;

  // One captured unit: the rising-edge sample and the falling-edge sample.
  typedef struct packed {
    logic [DICR_DATA_W-1:0] rise_capture_stream;
    logic [DICR_DATA_W-1:0] fall_capture_stream;
  } dicr_pair_t;

  localparam dicr_pair_t DICR_PAIR_RESET = '{
    rise_capture_stream: DICR_DATA_RESET,
    fall_capture_stream: DICR_DATA_RESET
  };

  // Strobe-domain state.
  typedef struct packed {
    logic [DICR_DATA_W-1:0] rise_capture;
    dicr_pair_t held;
    logic toggle;
  } dicr_strobe_state_t;
endpackage
`default_nettype wire

/* hdl/dicr_pair_buffer.sv */
// Two-entry buffer with valid and ready on both sides; outputs are flops.
`default_nettype none
module dicr_pair_buffer #(
  parameter int DEPTH = dicr_pkg::DICR_BUF_DEPTH
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire dicr_pkg::dicr_pair_t in_word,
  output logic out_valid,
  input wire logic out_ready,
  output dicr_pkg::dicr_pair_t out_word
);
  typedef struct packed {
    dicr_pkg::dicr_pair_t head;
    dicr_pkg::dicr_pair_t tail;
    logic head_valid;
    logic tail_valid;
  } dicr_buf_state_t;

  dicr_buf_state_t s;
  dicr_buf_state_t next_s;
  logic push;
  logic pop;

  initial begin
    if (DEPTH != 2) begin
      $error("dicr_pair_buffer supports only two entries");
    end
  end

  // The tail slot is the skid entry: ready drops only when both are full.
  assign in_ready = !s.tail_valid;
  assign out_valid = s.head_valid;
  assign out_word = s.head;
  assign push = in_valid && in_ready;
  assign pop = s.head_valid && out_ready;

  always_comb begin
    next_s = s;
    if (pop) begin
      next_s.head = s.tail;
      next_s.head_valid = s.tail_valid;
      next_s.tail_valid = 1'b0;
    end
    if (push) begin
      if (!next_s.head_valid) begin
        next_s.head = in_word;
        next_s.head_valid = 1'b1;
      end else begin
        next_s.tail = in_word;
        next_s.tail_valid = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s <= '{head: dicr_pkg::DICR_PAIR_RESET, tail: dicr_pkg::DICR_PAIR_RESET,
             head_valid: 1'b0, tail_valid: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  a_buf_no_loss: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    (s.head_valid && !out_ready) |=> (s.head_valid && s.head == $past(s.head)))
    else $error("buffer head changed while stalled");
endmodule
`default_nettype wire

/* hdl/dicr_capture.sv */
// Input capture register: SDR or strobe-timed DDR, re-timed to clk_sys.
// Function
// - Optional delay precedes the SDR input register only; the strobe registers take the pad data undelayed.
// - Exactly two modes: single and double rate.
// - SDR registers data once per system clock.
// - DDR samples rising and falling strobe edges.
// - Strobe streams re-registered into system clock domain.
// - Sync registers have reset and clock enable.
// - Polarity input picks the sync clock edge in DDR mode.
`default_nettype none
module dicr_capture #(
  parameter int DATA_W = dicr_pkg::DICR_DATA_W,
  parameter int DELAY_STAGES = dicr_pkg::DICR_DELAY_STAGES
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic strobe_clk,
  input wire logic [DATA_W-1:0] pad_data,
  input wire logic delay_enable,
  input wire logic ddr_mode_select,
  input wire logic sync_clock_polarity_select,
  input wire logic sync_reset,
  input wire logic sync_clock_enable,
  output logic out_valid,
  input wire logic out_ready,
  output dicr_pkg::dicr_pair_t out_word,
  output logic overrun
);
  localparam int DICR_SYNC_W = dicr_pkg::DICR_SYNC_FLOPS;

  typedef struct packed {
    logic [DICR_SYNC_W-1:0] toggle_sync;
    logic [DELAY_STAGES-1:0][DATA_W-1:0] delay_line;
    dicr_pkg::dicr_pair_t pend_word;
    logic pend_valid;
    logic overrun;
  } dicr_sys_state_t;

  dicr_sys_state_t s;
  dicr_sys_state_t next_s;
  dicr_pkg::dicr_strobe_state_t st;
  // The rising-edge sample lives apart from st so that each strobe edge
  // process owns its variables alone.
  logic [DATA_W-1:0] rise_sample;
  dicr_pkg::dicr_pair_t fall_sync_word;
  logic strobe_event;
  logic buf_ready;
  logic [DATA_W-1:0] sdr_source;

  initial begin
    if (DATA_W != dicr_pkg::DICR_DATA_W) begin
      $error("DATA_W must match the carrier width of the package");
    end
    if (DELAY_STAGES < 1) begin
      $error("DELAY_STAGES must be at least one");
    end
    if (DICR_SYNC_W != 3) begin
      $error("the strobe event needs exactly three sync stages");
    end
  end

  // Strobe domain: rising edge takes the first stream.
  always_ff @(posedge strobe_clk or negedge reset_n) begin
    if (!reset_n) begin
      rise_sample <= dicr_pkg::DICR_DATA_RESET;
    end else begin
      rise_sample <= pad_data;
    end
  end

  // The falling edge completes a pair and announces it with a toggle, so
  // the held pair stays stable for a whole strobe period while the
  // system side picks it up.
  always_ff @(negedge strobe_clk or negedge reset_n) begin
    if (!reset_n) begin
      st.rise_capture <= dicr_pkg::DICR_DATA_RESET;
      st.held <= dicr_pkg::DICR_PAIR_RESET;
      st.toggle <= 1'b0;
    end else begin
      st.rise_capture <= rise_sample;
      st.held.rise_capture_stream <= rise_sample;
      st.held.fall_capture_stream <= pad_data;
      st.toggle <= !st.toggle;
    end
  end

  // A new pair counts once the second and third stages differ, in DDR mode only.
  assign strobe_event = (s.toggle_sync[2] != s.toggle_sync[1])
    && (ddr_mode_select == dicr_pkg::DICR_MODE_DDR);

  // The delay line stands in for the pad delay; it is bypassed when off.
  assign sdr_source = delay_enable ? s.delay_line[DELAY_STAGES-1]
    : pad_data;

  // Falling-edge synchronising register, used when polarity is high.
  always_ff @(negedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fall_sync_word <= dicr_pkg::DICR_PAIR_RESET;
    end else if (sync_reset) begin
      fall_sync_word <= dicr_pkg::DICR_PAIR_RESET;
    end else if (sync_clock_enable && strobe_event
        && sync_clock_polarity_select == dicr_pkg::DICR_POL_FALL) begin
      fall_sync_word <= st.held;
    end
  end

  always_comb begin
    next_s = s;
    next_s.toggle_sync = {s.toggle_sync[1:0], st.toggle};
    next_s.delay_line[0] = pad_data;
    for (int i = 1; i < DELAY_STAGES; i++) begin
      next_s.delay_line[i] = s.delay_line[i-1];
    end
    if (s.pend_valid && buf_ready) begin
      next_s.pend_valid = 1'b0;
    end
    if (sync_reset) begin
      next_s.pend_word = dicr_pkg::DICR_PAIR_RESET;
      next_s.pend_valid = 1'b0;
      next_s.overrun = 1'b0;
    end else if (sync_clock_enable) begin
      if (ddr_mode_select == dicr_pkg::DICR_MODE_SDR) begin
        if (!next_s.pend_valid) begin
          next_s.pend_word.rise_capture_stream = sdr_source;
          next_s.pend_word.fall_capture_stream = dicr_pkg::DICR_DATA_RESET;
          next_s.pend_valid = 1'b1;
        end else begin
          next_s.overrun = 1'b1;
        end
      end else if (strobe_event) begin
        if (!next_s.pend_valid) begin
          next_s.pend_word = (sync_clock_polarity_select
            == dicr_pkg::DICR_POL_FALL) ? fall_sync_word : st.held;
          next_s.pend_valid = 1'b1;
        end else begin
          next_s.overrun = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s <= '{toggle_sync: '0, delay_line: '0,
             pend_word: dicr_pkg::DICR_PAIR_RESET, pend_valid: 1'b0,
             overrun: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign overrun = s.overrun;

  dicr_pair_buffer #(
    .DEPTH(dicr_pkg::DICR_BUF_DEPTH)
  ) u_buffer (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .in_valid(s.pend_valid),
    .in_ready(buf_ready),
    .in_word(s.pend_word),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_word(out_word)
  );

  a_delay_path_age: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    (delay_enable && $stable(delay_enable) && !sync_reset
     && sync_clock_enable && !s.pend_valid && !ddr_mode_select)
    |=> s.pend_word.rise_capture_stream == $past(s.delay_line[DELAY_STAGES-1]))
    else $error("delayed capture did not use the delay line");

  a_sdr_fall_zero: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    (!ddr_mode_select && !sync_reset && sync_clock_enable && !s.pend_valid)
    |=> s.pend_valid && s.pend_word.fall_capture_stream == '0)
    else $error("single rate capture filled the second stream");

  a_sdr_one_cycle: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    (!delay_enable && !ddr_mode_select && !sync_reset
     && sync_clock_enable && !s.pend_valid)
    |=> s.pend_word.rise_capture_stream == $past(pad_data))
    else $error("single rate capture missed the pad value");

  a_rise_strobe_cap: assert property (@(posedge strobe_clk)
    disable iff (!reset_n) 1'b1 |=> rise_sample == $past(pad_data))
    else $error("rising strobe sample wrong");

  a_fall_strobe_cap: assert property (@(negedge strobe_clk)
    disable iff (!reset_n)
    1'b1 |=> st.held.fall_capture_stream == $past(pad_data)
      && st.toggle != $past(st.toggle))
    else $error("falling strobe sample wrong");

  a_ddr_reaches_sys: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    (strobe_event && !sync_reset && sync_clock_enable && !s.pend_valid)
    |=> s.pend_valid)
    else $error("strobe pair not handed to system domain");

  a_ce_holds_word: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    (!sync_clock_enable && !sync_reset) |=> s.pend_word == $past(s.pend_word))
    else $error("clock enable low did not hold the register");

  a_reset_clears: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    sync_reset |=> !s.pend_valid && s.pend_word == '0 && !s.overrun)
    else $error("sync reset did not clear");

  a_overrun_sticky: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    (s.overrun && !sync_reset) |=> s.overrun)
    else $error("overrun flag cleared without sync reset");

  a_fall_reg_clear: assert property (@(negedge clk_sys)
    disable iff (!reset_n)
    sync_reset |=> fall_sync_word == '0)
    else $error("sync reset did not clear the falling register");

  a_pol_fall_edge: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    (strobe_event && sync_clock_polarity_select && !sync_reset
     && sync_clock_enable && !s.pend_valid)
    |=> s.pend_word == fall_sync_word)
    else $error("falling polarity did not use falling register");

  a_pol_rise_edge: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    (strobe_event && !sync_clock_polarity_select && !sync_reset
     && sync_clock_enable && !s.pend_valid)
    |=> s.pend_word == $past(st.held))
    else $error("rising polarity did not take the held pair");
endmodule
`default_nettype wire

/* tb/dicr_ddr_source.sv */
// Behavioural DDR source driving the data strobe and the pad data.
`default_nettype none
module dicr_ddr_source (
  output logic strobe_clk,
  output logic [dicr_pkg::DICR_DATA_W-1:0] pad_data
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    strobe_clk = 1'b0;
    pad_data = 8'h00;
  end
  // The strobe stands still between frames. Data is inverted once a frame
  // ends, so a late sample of stale data cannot match by chance.
  task automatic send_pair(input logic [7:0] rise, input logic [7:0] fall);
    pad_data = rise;
    #20 strobe_clk = 1'b1;
    #20 pad_data = fall;
    #20 strobe_clk = 1'b0;
    #20 pad_data = ~fall;
  endtask
endmodule
`default_nettype wire

/* tb/dicr_capture_tb.sv */
// Self-checking testbench of the DDR input capture register.
`default_nettype none
module dicr_capture_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, reset_n, strobe_clk, delay_enable, ddr_mode_select;
  logic sync_clock_polarity_select, sync_reset, sync_clock_enable;
  logic out_ready, out_valid, overrun;
  logic [7:0] tb_pad, src_pad;
  logic [7:0] hist [0:1];
  dicr_pkg::dicr_pair_t out_word, exp_word, ddr_word;
  dicr_pkg::dicr_pair_t exp_q [$];
  int n_fail, compares, i, k;
  integer seed;

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  dicr_ddr_source src_u (.strobe_clk(strobe_clk), .pad_data(src_pad));

  dicr_capture dut_u (
    .clk_sys(clk_sys), .reset_n(reset_n), .strobe_clk(strobe_clk),
    .pad_data(ddr_mode_select ? src_pad : tb_pad),
    .delay_enable(delay_enable), .ddr_mode_select(ddr_mode_select),
    .sync_clock_polarity_select(sync_clock_polarity_select),
    .sync_reset(sync_reset), .sync_clock_enable(sync_clock_enable),
    .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word),
    .overrun(overrun)
  );

  // Any accepted word without a pending note is a spurious load.
  always @(posedge clk_sys) begin
    if (reset_n === 1'b1 && out_valid === 1'b1 && out_ready === 1'b1) begin
      compares++;
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("BAD out_word exp none seen %h", out_word);
      end else begin
        exp_word = exp_q.pop_front();
        if (out_word !== exp_word) begin
          n_fail++;
          $display("BAD out_word exp %h seen %h", exp_word, out_word);
        end
      end
    end
  end

  task automatic print_verdict;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check1(input string name, input logic exp, input logic seen);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %b seen %b", name, exp, seen);
    end
  endtask

  task automatic drain;
    for (k = 0; k < 300 && exp_q.size() > 0; k++) @(negedge clk_sys);
    if (exp_q.size() > 0) begin
      n_fail++;
      $display("BAD drain exp 0 seen %0d", exp_q.size());
      print_verdict();
    end else begin
      repeat (10) @(negedge clk_sys);
    end
  endtask

  // The delayed path presents the pad value from two cycles earlier.
  task automatic sdr_run(input logic dly, input int n);
    delay_enable = dly;
    for (k = 0; k < n + 2; k++) begin
      @(negedge clk_sys);
      tb_pad = 8'($random(seed));
      sync_clock_enable = (k >= 2);
      if (k >= 2) exp_q.push_back('{dly ? hist[1] : tb_pad, 8'h00});
      hist[1] = hist[0];
      hist[0] = tb_pad;
    end
    @(negedge clk_sys);
    sync_clock_enable = 1'b0;
  endtask

  initial begin
    seed = 19741;
    reset_n = 1'b0;
    tb_pad = 8'h00;
    delay_enable = 1'b0;
    ddr_mode_select = 1'b0;
    sync_clock_polarity_select = 1'b0;
    sync_reset = 1'b0;
    sync_clock_enable = 1'b0;
    out_ready = 1'b1;
    repeat (3) @(negedge clk_sys);
    check1("out_valid", 1'b0, out_valid);
    reset_n = 1'b1;
    for (i = 0; i < 2; i++) sdr_run(i[0], 6);
    drain();
    delay_enable = 1'b0;
    out_ready = 1'b0;
    for (i = 0; i < 5; i++) begin
      tb_pad = 8'($random(seed));
      sync_clock_enable = 1'b1;
      if (i < 3) exp_q.push_back('{tb_pad, 8'h00});
      @(negedge clk_sys);
    end
    sync_clock_enable = 1'b0;
    repeat (3) @(negedge clk_sys);
    check1("overrun", 1'b1, overrun);
    out_ready = 1'b1;
    drain();
    sync_reset = 1'b1;
    @(negedge clk_sys);
    sync_reset = 1'b0;
    check1("overrun", 1'b0, overrun);
    ddr_mode_select = 1'b1;
    sync_clock_enable = 1'b1;
    for (i = 0; i < 2; i++) begin
      sync_clock_polarity_select = i[0];
      #3;
      for (k = 0; k < 4; k++) begin
        ddr_word = '{8'($random(seed)), 8'($random(seed))};
        exp_q.push_back(ddr_word);
        src_u.send_pair(ddr_word.rise_capture_stream,
          ddr_word.fall_capture_stream);
      end
      @(negedge clk_sys);
      drain();
    end
    print_verdict();
  end
endmodule
`default_nettype wire
